// ### common/iplr_pkg.sv
// Shared constants, types and register map of the interrupt priority level registers.
package iplr_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned REG_W       = 16;
    localparam int unsigned NUM_REGS    = 3;
    localparam int unsigned FIELD_W     = 2;
    localparam int unsigned NUM_SOURCES = 23;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_PRIORITY_REG_SEVEN      = 12'h007;
    localparam logic [ADDR_W-1:0] IDX_PRIORITY_SERIAL0_TIMERA = 12'h008;
    localparam logic [ADDR_W-1:0] IDX_PRIORITY_PWM_ADC        = 12'h009;

    // Slot of each register inside the stored register array.
    localparam int unsigned SLOT_SEVEN = 0;
    localparam int unsigned SLOT_EIGHT = 1;
    localparam int unsigned SLOT_NINE  = 2;

    // Reset values and writable bits per slot (reserved bits never store).
    localparam logic [REG_W-1:0] RESET_VALUE = 16'h0000;
    localparam logic [REG_W-1:0] MASK_SEVEN  = 16'hffff;
    localparam logic [REG_W-1:0] MASK_EIGHT  = 16'hf3ff;
    localparam logic [REG_W-1:0] MASK_NINE   = 16'hffff;

    // ------------------------------------------------------------------
    // Field positions (low bit of each 2-bit level field)
    // ------------------------------------------------------------------
    localparam int unsigned LSB_TIMER_A_CH0      = 14;
    localparam int unsigned LSB_TIMER_B_CH3      = 12;
    localparam int unsigned LSB_TIMER_B_CH2      = 10;
    localparam int unsigned LSB_TIMER_B_CH1      = 8;
    localparam int unsigned LSB_TIMER_B_CH0      = 6;
    localparam int unsigned LSB_TIMER_C_CH3      = 4;
    localparam int unsigned LSB_TIMER_C_CH2      = 2;
    localparam int unsigned LSB_TIMER_C_CH1      = 0;
    localparam int unsigned LSB_SERIAL0_RX_FULL  = 14;
    localparam int unsigned LSB_SERIAL0_RX_ERROR = 12;
    localparam int unsigned LSB_SERIAL0_TX_IDLE  = 8;
    localparam int unsigned LSB_SERIAL0_TX_EMPTY = 6;
    localparam int unsigned LSB_TIMER_A_CH3      = 4;
    localparam int unsigned LSB_TIMER_A_CH2      = 2;
    localparam int unsigned LSB_TIMER_A_CH1      = 0;
    localparam int unsigned LSB_PWM_A_FAULT      = 14;
    localparam int unsigned LSB_PWM_B_FAULT      = 12;
    localparam int unsigned LSB_PWM_A_RELOAD     = 10;
    localparam int unsigned LSB_PWM_B_RELOAD     = 8;
    localparam int unsigned LSB_ADC_A_ZERO_CROSS = 6;
    localparam int unsigned LSB_ADC_B_ZERO_CROSS = 4;
    localparam int unsigned LSB_ADC_A_CONV_DONE  = 2;
    localparam int unsigned LSB_ADC_B_CONV_DONE  = 0;

    // ------------------------------------------------------------------
    // Field encodings and bus responses
    // ------------------------------------------------------------------
    localparam logic [FIELD_W-1:0] FIELD_DISABLED = 2'h0;
    localparam logic [1:0]         RESP_OKAY      = 2'h0;
    localparam logic [1:0]         RESP_SLVERR    = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IPLR_IDLE,
        IPLR_WRITE_RESP,
        IPLR_READ_RESP
    } iplr_bus_state_t;

    // What each source hands to the arbitration logic.
    typedef struct packed {
        logic               req_enable;
        logic [FIELD_W-1:0] level;
    } iplr_source_t;

    typedef struct packed {
        iplr_bus_state_t                bus_state;
        logic                           aw_held;
        logic                           w_held;
        logic [ADDR_W-1:0]              awaddr;
        logic [REG_W-1:0]               wdata;
        logic [1:0]                     wstrb;
        logic [NUM_REGS-1:0][REG_W-1:0] prio;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           rvalid;
        logic [1:0]                     rresp;
        logic [DATA_W-1:0]              rdata;
        logic [NUM_SOURCES-1:0]         request;
    } iplr_state_t;

endpackage : iplr_pkg

// ### hdl/iplr_field_decode.sv
// Decoder from one 2-bit priority field to a request enable and a level.
`timescale 1ns/1ps
`default_nettype none

module iplr_field_decode
(
    // Programmed field.
    input  wire logic [iplr_pkg::FIELD_W-1:0] i_field,
    // Decoded source control.
    output var iplr_pkg::iplr_source_t         o_source
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------

    // Code 00 disables; codes 01, 10, 11 give levels 0, 1, 2, so level 3 is unreachable.
    always_comb
    begin
        o_source.req_enable = (i_field != iplr_pkg::FIELD_DISABLED);
        o_source.level      = i_field - 2'h1;
        if (i_field == iplr_pkg::FIELD_DISABLED)
        begin
            o_source.level = 2'h0;
        end
    end

endmodule : iplr_field_decode
`default_nettype wire

// ### hdl/iplr_reg_write.sv
// Byte-strobed, masked write merge for one 16-bit priority register.
`timescale 1ns/1ps
`default_nettype none

module iplr_reg_write
(
    // Current contents and the bits software may change.
    input  wire logic [iplr_pkg::REG_W-1:0] i_old,
    input  wire logic [iplr_pkg::REG_W-1:0] i_mask,
    // Write data and byte strobes from the bus.
    input  wire logic [iplr_pkg::REG_W-1:0] i_wdata,
    input  wire logic [1:0]                 i_wstrb,
    // Merged value.
    output logic      [iplr_pkg::REG_W-1:0] o_new
);

    // ------------------------------------------------------------------
    // Merge
    // ------------------------------------------------------------------

    logic [iplr_pkg::REG_W-1:0] lane;

    // A bit changes only when its byte is strobed and it is not reserved.
    always_comb
    begin
        lane  = {{8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
        o_new = (i_old & ~(lane & i_mask)) | (i_wdata & lane & i_mask);
    end

endmodule : iplr_reg_write
`default_nettype wire

// ### hdl/iplr_top.sv
// Interrupt priority level registers seven to nine behind an AXI4-Lite slave.
//
// Notes on behaviour
// - A field of 00 disables its source and 01, 10, 11 assign levels 0, 1 and 2, nothing higher.
// - After reset every field holds 00, so no covered source can request until programmed.
// - Bits 11 to 10 of the serial-port-0 and timer-A register read as zero and ignore writes.
// - Register seven holds timer B channel 2, 1 and 0 at bits 11-10, 9-8 and 7-6.
// - Register seven holds timer C channel 3, 2 and 1 at bits 5-4, 3-2 and 1-0.
// - Register eight holds serial 0 receiver full at bits 15-14 and receiver error at 13-12.
// - Register eight holds serial 0 transmitter idle at bits 9-8 and transmitter empty at 7-6.
// - Register eight holds timer A channel 3, 2 and 1 at bits 5-4, 3-2 and 1-0.
// - Register nine holds PWM A fault at bits 15-14 and PWM B fault at 13-12.
// - Register nine holds PWM A reload at bits 11-10 and PWM B reload at 9-8.
// - Register nine holds ADC A zero-crossing at bits 7-6 and ADC B zero-crossing at 5-4.
// - Register nine holds ADC A conversion done at bits 3-2 and ADC B at 1-0.
// - Registers eight and nine sit at word offsets 8 and 9 and are 16 bits wide.
// - Register seven holds timer A channel 0 at bits 15-14 and timer B channel 3 at 13-12.
`timescale 1ns/1ps
`default_nettype none

module iplr_top
(
    // Clock and reset.
    input  wire logic                                i_clock,
    input  wire logic                                i_rst,
    // AXI4-Lite write address channel.
    input  wire logic [iplr_pkg::ADDR_W-1:0]         i_awaddr,
    input  wire logic                                i_awvalid,
    output logic                                     o_awready,
    // AXI4-Lite write data channel.
    input  wire logic [iplr_pkg::DATA_W-1:0]         i_wdata,
    input  wire logic [3:0]                          i_wstrb,
    input  wire logic                                i_wvalid,
    output logic                                     o_wready,
    // AXI4-Lite write response channel.
    output logic [1:0]                               o_bresp,
    output logic                                     o_bvalid,
    input  wire logic                                i_bready,
    // AXI4-Lite read address channel.
    input  wire logic [iplr_pkg::ADDR_W-1:0]         i_araddr,
    input  wire logic                                i_arvalid,
    output logic                                     o_arready,
    // AXI4-Lite read data channel.
    output logic [iplr_pkg::DATA_W-1:0]              o_rdata,
    output logic [1:0]                               o_rresp,
    output logic                                     o_rvalid,
    input  wire logic                                i_rready,
    // Raw requests from the covered sources.
    input  wire logic [iplr_pkg::NUM_SOURCES-1:0]    i_source_request,
    // Towards arbitration and vectoring.
    output var iplr_pkg::iplr_source_t [iplr_pkg::NUM_SOURCES-1:0] o_source,
    output logic [iplr_pkg::NUM_SOURCES-1:0]         o_request
);

    // ----------------------------------------
    // State
    // ----------------------------------------

    iplr_pkg::iplr_state_t state;
    iplr_pkg::iplr_state_t next_state;

    // Register byte addresses and writable masks by slot.
    localparam logic [iplr_pkg::ADDR_W-1:0] ADDR_SEVEN =
        iplr_pkg::IDX_PRIORITY_REG_SEVEN << 2;
    localparam logic [iplr_pkg::ADDR_W-1:0] ADDR_EIGHT =
        iplr_pkg::IDX_PRIORITY_SERIAL0_TIMERA << 2;
    localparam logic [iplr_pkg::ADDR_W-1:0] ADDR_NINE =
        iplr_pkg::IDX_PRIORITY_PWM_ADC << 2;

    logic [iplr_pkg::NUM_REGS-1:0][iplr_pkg::REG_W-1:0] reg_mask;
    logic [iplr_pkg::NUM_REGS-1:0][iplr_pkg::REG_W-1:0] merged;

    // ----------------------------------------
    // Handshake terms
    // ----------------------------------------

    logic                          aw_fire;
    logic                          w_fire;
    logic                          ar_fire;
    logic                          have_aw;
    logic                          have_w;
    logic [iplr_pkg::ADDR_W-1:0]   cur_awaddr;
    logic [iplr_pkg::REG_W-1:0]    cur_wdata;
    logic [1:0]                    cur_wstrb;

    // Address and data are taken independently, one each, while idle.
    assign o_awready = (state.bus_state == iplr_pkg::IPLR_IDLE) && !state.aw_held;
    assign o_wready  = (state.bus_state == iplr_pkg::IPLR_IDLE) && !state.w_held;

    // Reads wait while any part of a write is offered or held; writes win a tie.
    assign o_arready = (state.bus_state == iplr_pkg::IPLR_IDLE)
                     && !state.aw_held && !state.w_held
                     && !i_awvalid && !i_wvalid;

    assign aw_fire = i_awvalid && o_awready;
    assign w_fire  = i_wvalid && o_wready;
    assign ar_fire = i_arvalid && o_arready;
    assign have_aw = state.aw_held || aw_fire;
    assign have_w  = state.w_held || w_fire;

    // The write uses what arrived this cycle, or what was held earlier.
    assign cur_awaddr = state.aw_held ? state.awaddr : i_awaddr;
    assign cur_wdata  = state.w_held ? state.wdata : i_wdata[iplr_pkg::REG_W-1:0];
    assign cur_wstrb  = state.w_held ? state.wstrb : i_wstrb[1:0];

    // ----------------------------------------
    // Write merge per register
    // ----------------------------------------

    // Reserved bits of register eight are removed by its mask.
    assign reg_mask[iplr_pkg::SLOT_SEVEN] = iplr_pkg::MASK_SEVEN;
    assign reg_mask[iplr_pkg::SLOT_EIGHT] = iplr_pkg::MASK_EIGHT;
    assign reg_mask[iplr_pkg::SLOT_NINE]  = iplr_pkg::MASK_NINE;

    generate
        for (genvar r = 0; r < iplr_pkg::NUM_REGS; r++)
        begin : g_merge
            iplr_reg_write u_reg_write
            (
                .i_old   (state.prio[r]),
                .i_mask  (reg_mask[r]),
                .i_wdata (cur_wdata),
                .i_wstrb (cur_wstrb),
                .o_new   (merged[r])
            );
        end
    endgenerate

    // ----------------------------------------
    // Address decode
    // ----------------------------------------

    logic [iplr_pkg::NUM_REGS-1:0] wr_hit;
    logic [iplr_pkg::NUM_REGS-1:0] rd_hit;
    logic [iplr_pkg::REG_W-1:0]    rd_value;

    // Low two address bits are ignored, so any byte of a word selects it.
    always_comb
    begin
        wr_hit[iplr_pkg::SLOT_SEVEN] = {cur_awaddr[11:2], 2'h0} == ADDR_SEVEN;
        wr_hit[iplr_pkg::SLOT_EIGHT] = {cur_awaddr[11:2], 2'h0} == ADDR_EIGHT;
        wr_hit[iplr_pkg::SLOT_NINE]  = {cur_awaddr[11:2], 2'h0} == ADDR_NINE;
        rd_hit[iplr_pkg::SLOT_SEVEN] = {i_araddr[11:2], 2'h0} == ADDR_SEVEN;
        rd_hit[iplr_pkg::SLOT_EIGHT] = {i_araddr[11:2], 2'h0} == ADDR_EIGHT;
        rd_hit[iplr_pkg::SLOT_NINE]  = {i_araddr[11:2], 2'h0} == ADDR_NINE;
    end

    // Read mux; reserved bits are masked again so they can never read as one.
    always_comb
    begin
        rd_value = 16'h0000;
        for (int r = 0; r < iplr_pkg::NUM_REGS; r++)
        begin
            if (rd_hit[r])
            begin
                rd_value = state.prio[r] & reg_mask[r];
            end
        end
    end

    // ----------------------------------------
    // Field extraction, one named source per line
    // ----------------------------------------

    logic [iplr_pkg::NUM_SOURCES-1:0][iplr_pkg::FIELD_W-1:0] field;
    logic [iplr_pkg::REG_W-1:0] reg7;
    logic [iplr_pkg::REG_W-1:0] reg8;
    logic [iplr_pkg::REG_W-1:0] reg9;

    assign reg7 = state.prio[iplr_pkg::SLOT_SEVEN];
    assign reg8 = state.prio[iplr_pkg::SLOT_EIGHT];
    assign reg9 = state.prio[iplr_pkg::SLOT_NINE];

    // Register seven: timer A channel 0, timers B and C.
    assign field[0]  = reg7[iplr_pkg::LSB_TIMER_A_CH0 +: 2];
    assign field[1]  = reg7[iplr_pkg::LSB_TIMER_B_CH3 +: 2];
    assign field[2]  = reg7[iplr_pkg::LSB_TIMER_B_CH2 +: 2];
    assign field[3]  = reg7[iplr_pkg::LSB_TIMER_B_CH1 +: 2];
    assign field[4]  = reg7[iplr_pkg::LSB_TIMER_B_CH0 +: 2];
    assign field[5]  = reg7[iplr_pkg::LSB_TIMER_C_CH3 +: 2];
    assign field[6]  = reg7[iplr_pkg::LSB_TIMER_C_CH2 +: 2];
    assign field[7]  = reg7[iplr_pkg::LSB_TIMER_C_CH1 +: 2];

    // Register eight: serial port 0 and timer A channels 3 to 1.
    assign field[8]  = reg8[iplr_pkg::LSB_SERIAL0_RX_FULL +: 2];
    assign field[9]  = reg8[iplr_pkg::LSB_SERIAL0_RX_ERROR +: 2];
    assign field[10] = reg8[iplr_pkg::LSB_SERIAL0_TX_IDLE +: 2];
    assign field[11] = reg8[iplr_pkg::LSB_SERIAL0_TX_EMPTY +: 2];
    assign field[12] = reg8[iplr_pkg::LSB_TIMER_A_CH3 +: 2];
    assign field[13] = reg8[iplr_pkg::LSB_TIMER_A_CH2 +: 2];
    assign field[14] = reg8[iplr_pkg::LSB_TIMER_A_CH1 +: 2];

    // Register nine: PWM fault and reload, ADC events.
    assign field[15] = reg9[iplr_pkg::LSB_PWM_A_FAULT +: 2];
    assign field[16] = reg9[iplr_pkg::LSB_PWM_B_FAULT +: 2];
    assign field[17] = reg9[iplr_pkg::LSB_PWM_A_RELOAD +: 2];
    assign field[18] = reg9[iplr_pkg::LSB_PWM_B_RELOAD +: 2];
    assign field[19] = reg9[iplr_pkg::LSB_ADC_A_ZERO_CROSS +: 2];
    assign field[20] = reg9[iplr_pkg::LSB_ADC_B_ZERO_CROSS +: 2];
    assign field[21] = reg9[iplr_pkg::LSB_ADC_A_CONV_DONE +: 2];
    assign field[22] = reg9[iplr_pkg::LSB_ADC_B_CONV_DONE +: 2];

    // ----------------------------------------
    // Per-source decode
    // ----------------------------------------

    generate
        for (genvar s = 0; s < iplr_pkg::NUM_SOURCES; s++)
        begin : g_source
            // Level and enable follow the register flops with no added delay.
            iplr_field_decode u_decode
            (
                .i_field  (field[s]),
                .o_source (o_source[s])
            );
        end
    endgenerate

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------

    // One pass covers the bus sequence, register updates and request gating.
    always_comb
    begin
        next_state = state;

        // A source is forwarded only while its field is not disabled.
        for (int s = 0; s < iplr_pkg::NUM_SOURCES; s++)
        begin
            next_state.request[s] = i_source_request[s] && o_source[s].req_enable;
        end

        unique case (state.bus_state)
            iplr_pkg::IPLR_IDLE:
            begin
                if (aw_fire)
                begin
                    next_state.aw_held = 1'b1;
                    next_state.awaddr  = i_awaddr;
                end
                if (w_fire)
                begin
                    next_state.w_held = 1'b1;
                    next_state.wdata  = i_wdata[iplr_pkg::REG_W-1:0];
                    next_state.wstrb  = i_wstrb[1:0];
                end
                if (have_aw && have_w)
                begin
                    // Both halves present: commit and answer the next cycle.
                    for (int r = 0; r < iplr_pkg::NUM_REGS; r++)
                    begin
                        if (wr_hit[r])
                        begin
                            next_state.prio[r] = merged[r];
                        end
                    end
                    next_state.aw_held   = 1'b0;
                    next_state.w_held    = 1'b0;
                    next_state.bvalid    = 1'b1;
                    next_state.bresp     = (|wr_hit) ? iplr_pkg::RESP_OKAY
                                                     : iplr_pkg::RESP_SLVERR;
                    next_state.bus_state = iplr_pkg::IPLR_WRITE_RESP;
                end
                else if (ar_fire)
                begin
                    // Unmapped reads return zero with an error response.
                    next_state.rdata     = {16'h0000, rd_value};
                    next_state.rvalid    = 1'b1;
                    next_state.rresp     = (|rd_hit) ? iplr_pkg::RESP_OKAY
                                                     : iplr_pkg::RESP_SLVERR;
                    next_state.bus_state = iplr_pkg::IPLR_READ_RESP;
                end
            end
            iplr_pkg::IPLR_WRITE_RESP:
            begin
                if (i_bready)
                begin
                    next_state.bvalid    = 1'b0;
                    next_state.bresp     = iplr_pkg::RESP_OKAY;
                    next_state.bus_state = iplr_pkg::IPLR_IDLE;
                end
            end
            iplr_pkg::IPLR_READ_RESP:
            begin
                if (i_rready)
                begin
                    next_state.rvalid    = 1'b0;
                    next_state.rresp     = iplr_pkg::RESP_OKAY;
                    next_state.bus_state = iplr_pkg::IPLR_IDLE;
                end
            end
            default:
            begin
                // The fourth code of the state field is never entered; recover.
                next_state.bus_state = iplr_pkg::IPLR_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------

    // Every field comes out of reset disabled.
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state           <= '0;
            state.bus_state <= iplr_pkg::IPLR_IDLE;
            state.prio      <= {iplr_pkg::NUM_REGS{iplr_pkg::RESET_VALUE}};
            state.bresp     <= iplr_pkg::RESP_OKAY;
            state.rresp     <= iplr_pkg::RESP_OKAY;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // Response channels and forwarded requests come straight from flops.
    assign o_bvalid  = state.bvalid;
    assign o_bresp   = state.bresp;
    assign o_rvalid  = state.rvalid;
    assign o_rresp   = state.rresp;
    assign o_rdata   = state.rdata;
    assign o_request = state.request;

endmodule : iplr_top
`default_nettype wire

// ### verification/iplr_props.sv
// Property checker for the interrupt priority level registers.
`timescale 1ns/1ps
`default_nettype none
module iplr_props
(
    // Clock and reset.
    input wire logic                          i_clock,
    input wire logic                          i_rst,
    // Bus handshakes and read data.
    input wire logic                          i_awvalid,
    input wire logic                          o_awready,
    input wire logic                          i_wvalid,
    input wire logic                          o_wready,
    input wire logic                          o_bvalid,
    input wire logic                          i_bready,
    input wire logic                          i_arvalid,
    input wire logic                          o_arready,
    input wire logic                          o_rvalid,
    input wire logic                          i_rready,
    input wire logic [31:0]                   o_rdata,
    // Source path towards arbitration.
    input wire iplr_pkg::iplr_source_t [22:0] o_source,
    input wire logic [22:0]                   o_request
);
    // ----------------------------------------
    // Bus timing and source gating properties
    // ----------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // Both write halves taken at one edge, the case the bench produces.
    sequence wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    resp_after_write_a: assert property (wr_taken |=> o_bvalid) else $error("no write response");
    bresp_held_a: assert property (o_bvalid && !i_bready |=> o_bvalid) else $error("bvalid dropped");
    resp_after_read_a: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("no read response");
    rdata_held_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");
    upper_zero_a: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    busy_stall_a: assert property (o_bvalid || o_rvalid |-> !o_awready && !o_arready)
        else $error("ready while answering");
    level_range_a: assert property (o_source[8].level != 2'h3 && (o_source[8].req_enable
        || o_source[8].level == 2'h0)) else $error("level out of range");
    disabled_gate_a: assert property (o_request[8] |-> $past(o_source[8].req_enable))
        else $error("disabled source forwarded");
    reset_clear_a: assert property ($fell(i_rst) |-> o_source == '0 && o_request == '0)
        else $error("fields not cleared by reset");
endmodule : iplr_props
bind iplr_top iplr_props i_props (.*);
`default_nettype wire

// ### verification/iplr_bench.sv
// Self-checking bench for the interrupt priority level registers.
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_level_regs_bench;
    // ----------------------------------------
    // Stimulus, shadow registers and expected results
    // ----------------------------------------
    logic        i_clock = 1'b0, i_rst = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [11:0] i_awaddr = '0, i_araddr = '0;
    logic [31:0] i_wdata = '0, o_rdata, seed = 32'h4946aeac;
    logic [3:0]  i_wstrb = '0;
    logic [1:0]  o_bresp, o_rresp;
    logic [22:0] i_source_request = '0, o_request, exp_req;
    logic [15:0] sh [3] = '{default: 16'h0000};
    logic [33:0] q [$];
    int          miscompares = 0, n_compared = 0;
    iplr_pkg::iplr_source_t [22:0] o_source;
    iplr_top i_dut (.*);
    initial forever #5 i_clock = ~i_clock;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Expected field of a source; register eight skips its reserved pair.
    function automatic logic [1:0] fld(input int s);
        int r, j;
        r = (s < 8) ? 0 : (s < 15) ? 1 : 2;
        j = s - ((r == 0) ? 0 : (r == 1) ? 8 : 15);
        j = 14 - 2 * j - ((r == 1 && j > 1) ? 2 : 0);
        return sh[r][j +: 2];
    endfunction : fld
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // Address and data offered together, each dropped on the edge it is taken.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        logic pa = 1'b1, pw = 1'b1;
        q.push_back({r, 32'h0});
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        while (pa || pw)
        begin
            @(posedge i_clock);
            if (pa && o_awready) i_awvalid <= 1'b0;
            if (pw && o_wready) i_wvalid <= 1'b0;
            pa &= !o_awready;
            pw &= !o_wready;
        end
        @(posedge i_clock iff (o_bvalid && i_bready));
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        q.push_back(e);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        @(posedge i_clock iff o_arready);
        i_arvalid <= 1'b0;
        @(posedge i_clock iff (o_rvalid && i_rready));
    endtask : rd
    task automatic chk_src();
        for (int s = 0; s < 23; s++)
            chk("source", {31'h0, |fld(s), fld(s) - 2'(|fld(s))}, 34'(o_source[s]));
        @(negedge i_clock);
        for (int s = 0; s < 23; s++) exp_req[s] = i_source_request[s] && fld(s) != 2'h0;
        @(negedge i_clock);
        chk("request", 34'(exp_req), 34'(o_request));
        @(posedge i_clock);
    endtask : chk_src
    // Random sources and ready lines; a raised ready stays up until answered.
    always @(posedge i_clock)
    begin
        i_source_request <= 23'(rnd());
        if (!i_bready || o_bvalid) i_bready <= seed[5];
        if (!i_rready || o_rvalid) i_rready <= seed[9];
    end
    // Each bus answer is matched against the oldest expectation.
    always @(posedge i_clock)
        if (o_bvalid && i_bready) chk("write response", q.pop_front(), {o_bresp, 32'h0});
        else if (o_rvalid && i_rready) chk("read", q.pop_front(), {o_rresp, o_rdata});
    initial
    begin
        int r;
        logic [31:0] d;
        logic [3:0] s;
        logic [15:0] m;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        chk_src();
        for (r = 0; r < 3; r++) rd(12'h01c + 12'(4 * r), 34'h0);
        for (int n = 0; n < 40; n++)
        begin
            r = int'(rnd() % 3);
            d = rnd();
            s = 4'(rnd());
            m = {{8{s[1]}}, {8{s[0]}}} & ((r == 1) ? 16'hf3ff : 16'hffff);
            sh[r] = (sh[r] & ~m) | (d[15:0] & m);
            wr(12'h01c + 12'(4 * r), d, s, 2'h0);
            rd(12'h01c + 12'(4 * r), {18'h0, sh[r]});
            chk_src();
        end
        wr(12'h028, 32'hffffffff, 4'hf, 2'h2);
        rd(12'h000, {2'h2, 32'h0});
        chk_src();
        close_out();
    end
    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge i_clock);
        miscompares++;
        close_out();
    end
endmodule : interrupt_priority_level_regs_bench
`default_nettype wire
